/* verilog/psm_power_state_manager.sv */
// Operation
// - Exactly five power states: full-run, idle-slow, display-off, suspended, powered-off.
// - Full-run runs at full clock unless the governor slows it, with all activities enabled.
// - Idle-slow slows or halts the clock; entry timer in seconds at index CCH.
// - Display-off turns the display off; entry timer in minutes at index CDH.
// - Suspended stops oscillator, self-refreshes memory; entry timer minutes at CEH.
// - Powered-off stops oscillator and refresh; lowest power.
// - State timer expiring without activity moves to the next lower state.
// - Timer expiry may slow the clock or raise an idle interrupt.
// - A mask per activity gates interrupts and state changes.
// - Clock governor watches activity and lowers or raises the clock rate.
// - CPU clock runs at normal or reduced speed under manager control.
// - Separate power outputs; bias and LCD outputs can float.
// - Writable registers hold timers, pin control settings and activity masks.
// - Button low over 60 ms then high resumes from suspend, interrupts when awake, is ignored in powered-off.
// - Programmed count of ring rising edges resumes from suspended or off.
// - System power output asserts at the start of every resume.
// - After power good, wait programmed 0 to 250 ms before resuming.
//
// The APB slave port was decided locally.
`default_nettype none
module psm_power_state_manager
   import psm_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS,
   parameter int MS_SEC = MS_PER_SEC,
   parameter int SEC_MIN = SEC_PER_MIN
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Activity strobes from on-chip logic
   input wire logic [7:0] activity_in,
   // Pins
   input wire logic power_button_in,
   input wire logic system_power_good_in,
   input wire logic battery_critical_in,
   input wire logic battery_caution_in,
   input wire logic ring_wake_in,
   input wire logic main_reset_in,
   // Power switches
   output logic system_power_out,
   output logic memory_power_out,
   output logic lcd_bias_power_out,
   output logic lcd_bias_power_oe,
   output logic lcd_power_out,
   output logic lcd_power_oe,
   // Clock and oscillator control
   output logic cpu_clk_slow,
   output logic cpu_clk_halt,
   output logic osc_stop,
   output logic self_refresh,
   // Status
   output logic [2:0] power_state,
   output logic irq
);
   typedef struct packed {
      logic [5:0] sy1;
      logic [5:0] sy2;
      logic [5:0] sy3;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] ctrl;
      logic [7:0] act_mask;
      logic [7:0] irq_st;
      logic [7:0] irq_mask;
      logic [7:0] t_idle;
      logic [7:0] t_disp;
      logic [7:0] t_susp;
      logic [7:0] resume_ms;
      psm_state_e st;
      logic resuming;
      logic [7:0] dly;
      logic [7:0] tmr;
      logic [6:0] btn_ms;
      logic [3:0] ring_cnt;
      logic [2:0] gov_ms;
      logic slow;
      logic halt;
      logic irq;
      logic sys_pwr;
      logic mem_pwr;
      logic bias_pwr;
      logic bias_oe;
      logic lcd_pwr;
      logic lcd_oe;
      logic osc_stop;
      logic refresh;
   } psm_core_s;

   localparam psm_core_s CORE_RST = '{ctrl: CONTROL_RST, act_mask: ACT_MASK_RST, t_idle: TIMER_RST,
      t_disp: TIMER_RST, t_susp: TIMER_RST, resume_ms: RESUME_RST, st: PSM_FULL_RUN,
      sys_pwr: 1'b1, mem_pwr: 1'b1, bias_pwr: 1'b1, bias_oe: 1'b1, lcd_pwr: 1'b1, lcd_oe: 1'b1,
      sy1: 6'h21, sy2: 6'h21, sy3: 6'h21, default: '0};

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   function automatic logic psm_mapped(input logic [11:0] a);
      logic [7:0] i;
      i = a[9:2];
      psm_mapped = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
         ((i == IDX_STATE) || (i == IDX_COMMAND) || (i == IDX_CONTROL) || (i == IDX_ACT_MASK) ||
          (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK) || (i == IDX_IDLE_TIMER) ||
          (i == IDX_DISP_TIMER) || (i == IDX_SUSP_TIMER) || (i == IDX_RESUME_DLY));
   endfunction

   function automatic logic psm_wr(input logic [11:0] a, input logic [7:0] idx, input logic go);
      psm_wr = go && psm_mapped(a) && (a[9:2] == idx);
   endfunction

   psm_tick_if tk ();

   psm_tick_gen #(
      .CYC_MS(CYC_MS),
      .MS_SEC(MS_SEC),
      .SEC_MIN(SEC_MIN)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tick(tk)
   );

   psm_core_s q;
   psm_core_s d;

   logic acc;
   logic wr_go;
   logic act;
   logic unit;
   logic expire;
   logic btn_release;
   logic ring_rise;
   logic awake;
   logic [7:0] lim;
   logic [7:0] rd_val;
   logic [7:0] ev;
   logic [7:0] dly_lim;
   logic [7:0] w1c;
   logic [1:0] cmd;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      ev = '0;
      // Only the second stage is looked at; sy3 is its delayed copy for edges
      d.sy1 = {main_reset_in, ring_wake_in, battery_caution_in, battery_critical_in,
               system_power_good_in, power_button_in};
      d.sy2 = q.sy1;
      d.sy3 = q.sy2;
      act = |(activity_in & q.act_mask);
      awake = (q.st == PSM_FULL_RUN) || (q.st == PSM_IDLE_SLOW) || (q.st == PSM_DISPLAY_OFF);

      // APB: one wait state; read data lands on the edge that raises pready, write data on the edge after it
      acc = psel && penable;
      wr_go = acc && q.pready && pwrite;
      d.pready = acc && !q.pready;
      d.pslverr = 1'b0;
      d.prdata = '0;
      case (paddr[9:2])
         IDX_STATE: rd_val = {4'h0, q.resuming, q.st};
         IDX_CONTROL: rd_val = q.ctrl;
         IDX_ACT_MASK: rd_val = q.act_mask;
         IDX_IRQ_STATUS: rd_val = q.irq_st;
         IDX_IRQ_MASK: rd_val = q.irq_mask;
         IDX_IDLE_TIMER: rd_val = q.t_idle;
         IDX_DISP_TIMER: rd_val = q.t_disp;
         IDX_SUSP_TIMER: rd_val = q.t_susp;
         IDX_RESUME_DLY: rd_val = q.resume_ms;
         default: rd_val = 8'h00;
      endcase
      if (acc && !q.pready) begin
         d.pslverr = !psm_mapped(paddr);
         if (!pwrite && psm_mapped(paddr)) begin
            d.prdata = {24'h000000, rd_val};
         end
      end
      if (psm_wr(paddr, IDX_CONTROL, wr_go)) d.ctrl = pwdata[7:0];
      if (psm_wr(paddr, IDX_ACT_MASK, wr_go)) d.act_mask = pwdata[7:0];
      if (psm_wr(paddr, IDX_IRQ_MASK, wr_go)) d.irq_mask = pwdata[7:0];
      if (psm_wr(paddr, IDX_IDLE_TIMER, wr_go)) d.t_idle = pwdata[7:0];
      if (psm_wr(paddr, IDX_DISP_TIMER, wr_go)) d.t_disp = pwdata[7:0];
      if (psm_wr(paddr, IDX_SUSP_TIMER, wr_go)) d.t_susp = pwdata[7:0];
      if (psm_wr(paddr, IDX_RESUME_DLY, wr_go)) d.resume_ms = pwdata[7:0];
      w1c = psm_wr(paddr, IDX_IRQ_STATUS, wr_go) ? pwdata[7:0] : 8'h00;
      cmd = psm_wr(paddr, IDX_COMMAND, wr_go) ? pwdata[1:0] : 2'b00;

      // Power button: count whole ms held low, saturating just past the hold time
      btn_release = q.sy2[0] && !q.sy3[0] && (q.btn_ms > BUTTON_HOLD_MS);
      if (q.sy2[0]) begin
         d.btn_ms = '0;
      end else if (tk.ms && (q.btn_ms <= BUTTON_HOLD_MS)) begin
         d.btn_ms = q.btn_ms + 7'd1;
      end
      ring_rise = q.sy2[4] && !q.sy3[4];
      ev[EV_BATT_CRIT] = q.sy2[2] && !q.sy3[2];
      ev[EV_BATT_CAUT] = q.sy2[3] && !q.sy3[3] && awake;
      ev[EV_BUTTON] = btn_release && awake;
      ev[EV_ACTIVITY] = act && awake;

      // State timer: seconds in full-run, minutes further down
      unit = (q.st == PSM_FULL_RUN) ? tk.sec : tk.min;
      case (q.st)
         PSM_FULL_RUN: lim = q.t_idle;
         PSM_IDLE_SLOW: lim = q.t_disp;
         PSM_DISPLAY_OFF: lim = q.t_susp;
         default: lim = 8'h00;
      endcase
      expire = unit && !act && (lim != 8'h00) && (q.tmr >= lim - 8'd1);
      if (act || expire) begin
         d.tmr = '0;
      end else if (unit && (q.tmr != 8'hff)) begin
         d.tmr = q.tmr + 8'd1;
      end

      // Power state sequencing
      dly_lim = (q.resume_ms > RESUME_MAX_MS) ? RESUME_MAX_MS : q.resume_ms;
      case (q.st)
         PSM_FULL_RUN: begin
            if (expire) begin
               d.st = PSM_IDLE_SLOW;
               ev[EV_IDLE] = 1'b1;
            end
         end
         PSM_IDLE_SLOW: begin
            if (act) d.st = PSM_FULL_RUN;
            else if (expire) d.st = PSM_DISPLAY_OFF;
         end
         PSM_DISPLAY_OFF: begin
            if (act) d.st = PSM_FULL_RUN;
            else if (expire) d.st = PSM_SUSPENDED;
         end
         PSM_SUSPENDED, PSM_POWERED_OFF: begin
            if (ring_rise && (q.ctrl[CTL_RING_LSB +: 4] != 4'h0)) d.ring_cnt = q.ring_cnt + 4'd1;
            if (!q.resuming) begin
               if ((ring_rise && (q.ring_cnt + 4'd1 == q.ctrl[CTL_RING_LSB +: 4]) &&
                    (q.ctrl[CTL_RING_LSB +: 4] != 4'h0)) ||
                   (btn_release && (q.st == PSM_SUSPENDED))) begin
                  d.resuming = 1'b1;
                  d.dly = '0;
               end
            end else if (q.sy2[1]) begin
               if (q.dly >= dly_lim) begin
                  d.st = PSM_FULL_RUN;
                  d.resuming = 1'b0;
                  d.ring_cnt = '0;
                  ev[EV_RESUMED] = 1'b1;
               end else if (tk.ms) begin
                  d.dly = q.dly + 8'd1;
               end
            end
         end
         default: d.st = PSM_FULL_RUN;
      endcase
      if (awake && cmd[CMD_OFF]) begin
         d.st = PSM_POWERED_OFF;
      end else if (awake && cmd[CMD_SUSPEND]) begin
         d.st = PSM_SUSPENDED;
      end
      if (d.st != q.st) begin
         d.tmr = '0;
      end
      // External main reset forces a fresh full-run start
      if (!q.sy2[5]) begin
         d.st = PSM_FULL_RUN;
         d.resuming = 1'b0;
         d.tmr = '0;
         d.ring_cnt = '0;
      end

      // Clock governor; it only steers the clock in full-run
      if (act || !q.ctrl[CTL_GOV_EN]) begin
         d.gov_ms = '0;
      end else if (tk.ms && (q.gov_ms != GOV_HOLD_MS)) begin
         d.gov_ms = q.gov_ms + 3'd1;
      end
      case (d.st)
         PSM_FULL_RUN: begin
            d.slow = q.ctrl[CTL_GOV_EN] && !act && (d.gov_ms == GOV_HOLD_MS);
            d.halt = 1'b0;
         end
         PSM_IDLE_SLOW: begin
            d.slow = 1'b1;
            d.halt = q.ctrl[CTL_IDLE_HALT];
         end
         default: begin
            d.slow = 1'b1;
            d.halt = 1'b1;
         end
      endcase

      // Status: an event in the clearing cycle stays set
      d.irq_st = (q.irq_st & ~w1c) | ev;
      d.irq = |(d.irq_st & d.irq_mask);

      // Power pins follow the next state so they switch with it
      d.sys_pwr = (d.st != PSM_SUSPENDED && d.st != PSM_POWERED_OFF) || d.resuming;
      d.mem_pwr = (d.st != PSM_POWERED_OFF);
      d.bias_pwr = (d.st == PSM_FULL_RUN) || (d.st == PSM_IDLE_SLOW);
      d.lcd_pwr = d.bias_pwr;
      // Floating the off outputs lets an external pull decide the rail
      d.bias_oe = d.bias_pwr || !d.ctrl[CTL_LCD_FLOAT];
      d.lcd_oe = d.bias_oe;
      d.osc_stop = (d.st == PSM_SUSPENDED || d.st == PSM_POWERED_OFF) && !d.resuming;
      d.refresh = (d.st == PSM_SUSPENDED);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= CORE_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign system_power_out = q.sys_pwr;
   assign memory_power_out = q.mem_pwr;
   assign lcd_bias_power_out = q.bias_pwr;
   assign lcd_bias_power_oe = q.bias_oe;
   assign lcd_power_out = q.lcd_pwr;
   assign lcd_power_oe = q.lcd_oe;
   assign cpu_clk_slow = q.slow;
   assign cpu_clk_halt = q.halt;
   assign osc_stop = q.osc_stop;
   assign self_refresh = q.refresh;
   assign power_state = q.st;
   assign irq = q.irq;
endmodule : psm_power_state_manager
`default_nettype wire

/* verilog/psm_pkg.sv */
`default_nettype none
package psm_pkg;
   // ------------------------------------------------------------------
   // Power states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      PSM_FULL_RUN    = 3'b000,
      PSM_IDLE_SLOW   = 3'b001,
      PSM_DISPLAY_OFF = 3'b010,
      PSM_SUSPENDED   = 3'b011,
      PSM_POWERED_OFF = 3'b100
   } psm_state_e;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_STATE       = 8'hc0;
   localparam logic [7:0] IDX_COMMAND     = 8'hc1;
   localparam logic [7:0] IDX_CONTROL     = 8'hc2;
   localparam logic [7:0] IDX_ACT_MASK    = 8'hc8;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'hc9;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'hca;
   localparam logic [7:0] IDX_IDLE_TIMER  = 8'hcc;
   localparam logic [7:0] IDX_DISP_TIMER  = 8'hcd;
   localparam logic [7:0] IDX_SUSP_TIMER  = 8'hce;
   localparam logic [7:0] IDX_RESUME_DLY  = 8'hdd;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTL_RING_LSB  = 0;
   localparam int CTL_GOV_EN    = 4;
   localparam int CTL_IDLE_HALT = 5;
   localparam int CTL_LCD_FLOAT = 6;
   localparam int CMD_SUSPEND   = 0;
   localparam int CMD_OFF       = 1;
   localparam int EV_IDLE       = 0;
   localparam int EV_BUTTON     = 1;
   localparam int EV_BATT_CRIT  = 2;
   localparam int EV_BATT_CAUT  = 3;
   localparam int EV_RESUMED    = 4;
   localparam int EV_ACTIVITY   = 5;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic [7:0] ACT_MASK_RST = 8'hff;
   localparam logic [7:0] TIMER_RST    = 8'h00;
   localparam logic [7:0] RESUME_RST   = 8'h00;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
   localparam int MS_PER_SEC    = 1000;
   localparam int SEC_PER_MIN   = 60;
   localparam logic [6:0] BUTTON_HOLD_MS = 7'd60;
   localparam logic [7:0] RESUME_MAX_MS  = 8'd250;
   localparam logic [2:0] GOV_HOLD_MS    = 3'd4;
endpackage : psm_pkg
`default_nettype wire

/* verilog/psm_tick_if.sv */
`default_nettype none
interface psm_tick_if;
   logic ms;
   logic sec;
   logic min;
   modport src (output ms, output sec, output min);
   modport dst (input ms, input sec, input min);
endinterface : psm_tick_if
`default_nettype wire

/* verilog/psm_tick_gen.sv */
`default_nettype none
module psm_tick_gen
   import psm_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS,
   parameter int MS_SEC = MS_PER_SEC,
   parameter int SEC_MIN = SEC_PER_MIN
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Time base
   psm_tick_if.src tick
);
   typedef struct packed {
      logic [31:0] cyc;
      logic [31:0] ms;
      logic [31:0] sec;
      logic p_ms;
      logic p_sec;
      logic p_min;
   } psm_tick_s;

   psm_tick_s q;
   psm_tick_s d;

   always_comb begin
      d = q;
      d.p_ms = 1'b0;
      d.p_sec = 1'b0;
      d.p_min = 1'b0;
      if (q.cyc >= 32'(CYC_MS - 1)) begin
         d.cyc = '0;
         d.p_ms = 1'b1;
         if (q.ms >= 32'(MS_SEC - 1)) begin
            d.ms = '0;
            d.p_sec = 1'b1;
            if (q.sec >= 32'(SEC_MIN - 1)) begin
               d.sec = '0;
               d.p_min = 1'b1;
            end else begin
               d.sec = q.sec + 32'd1;
            end
         end else begin
            d.ms = q.ms + 32'd1;
         end
      end else begin
         d.cyc = q.cyc + 32'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign tick.ms = q.p_ms;
   assign tick.sec = q.p_sec;
   assign tick.min = q.p_min;
endmodule : psm_tick_gen
`default_nettype wire

/* tb/psm_props.sv */
`default_nettype none
module psm_props
   import psm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic pready,
   // Power
   input wire logic system_power_good_in,
   input wire logic system_power_out,
   input wire logic cpu_clk_slow,
   input wire logic cpu_clk_halt,
   input wire logic osc_stop,
   input wire logic self_refresh,
   input wire logic [2:0] power_state
);
   // ----
   // Properties
   // ----
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_state_range;
      power_state <= 3'h4;
   endproperty
   a_state_range: assert property (p_state_range) else $error("power state out of range");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_full_run;
      (power_state == PSM_FULL_RUN) [*3] |-> !osc_stop && !self_refresh && !cpu_clk_halt;
   endproperty
   a_full_run: assert property (p_full_run) else $error("full run not at full power");
   property p_idle_slow;
      (power_state == PSM_IDLE_SLOW) [*3] |-> cpu_clk_slow && !osc_stop;
   endproperty
   a_idle_slow: assert property (p_idle_slow) else $error("idle slow clock not slowed");
   property p_suspended;
      (power_state == PSM_SUSPENDED) [*3] |-> (osc_stop == !system_power_out) && self_refresh && cpu_clk_halt;
   endproperty
   a_suspended: assert property (p_suspended) else $error("suspend outputs wrong");
   property p_off;
      (power_state == PSM_POWERED_OFF) [*3] |-> (osc_stop == !system_power_out) && !self_refresh;
   endproperty
   a_off: assert property (p_off) else $error("off outputs wrong");
   property p_resume_power;
      ($past(power_state) >= 3'h3) && (power_state == PSM_FULL_RUN) |-> $past(system_power_out, 2);
   endproperty
   a_resume_power: assert property (p_resume_power) else $error("resume without system power");
   property p_resume_good;
      ($past(power_state) >= 3'h3) && (power_state == PSM_FULL_RUN) |-> $past(system_power_good_in, 2);
   endproperty
   a_resume_good: assert property (p_resume_good) else $error("resume without power good");
endmodule // psm_props

bind psm_power_state_manager psm_props u_props (
   .pclk(pclk), .presetn(presetn), .pready(pready),
   .system_power_good_in(system_power_good_in), .system_power_out(system_power_out),
   .cpu_clk_slow(cpu_clk_slow), .cpu_clk_halt(cpu_clk_halt), .osc_stop(osc_stop),
   .self_refresh(self_refresh), .power_state(power_state)
);
`default_nettype wire

/* tb/psm_supply_model.sv */
`default_nettype none
module psm_supply_model #(
   parameter int PG_DELAY = 16
) (
   // Rail
   input wire logic pclk,
   input wire logic system_power_out,
   output logic system_power_good_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   initial begin
      cnt = 0;
      system_power_good_in = 1'b0;
   end
   // Good only after the rail has settled; drops at once when switched off
   always @(posedge pclk) begin
      if (!system_power_out) begin
         cnt <= 0;
         system_power_good_in <= 1'b0;
      end else if (cnt < PG_DELAY) begin
         cnt <= cnt + 1;
      end else begin
         system_power_good_in <= 1'b1;
      end
   end
endmodule // psm_supply_model
`default_nettype wire

/* tb/test_power_state_manager.sv */
`default_nettype none
module test_power_state_manager
   import psm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CMS = 4;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, btn, pgood, bcrit, bcaut, ring, rst_n, irq;
   logic sys_pwr, slow, halt, osc, srf;
   logic mem, bias, bias_oe, lcd, lcd_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] act;
   logic [2:0] state;
   int n_fail = 0;
   int total_checks = 0;
   int n;
   psm_power_state_manager #(.CYC_MS(CMS), .MS_SEC(3), .SEC_MIN(2)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .activity_in(act), .power_button_in(btn), .system_power_good_in(pgood),
      .battery_critical_in(bcrit), .battery_caution_in(bcaut), .ring_wake_in(ring),
      .main_reset_in(rst_n), .system_power_out(sys_pwr), .memory_power_out(mem), .lcd_bias_power_out(bias),
      .lcd_bias_power_oe(bias_oe), .lcd_power_out(lcd), .lcd_power_oe(lcd_oe), .cpu_clk_slow(slow),
      .cpu_clk_halt(halt),
      .osc_stop(osc), .self_refresh(srf), .power_state(state), .irq(irq));
   psm_supply_model u_supply (.pclk(pclk), .system_power_out(sys_pwr), .system_power_good_in(pgood));
   always #5 pclk = ~pclk;
   // ----
   // Helpers
   // ----
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Holds the request until pready is seen at an edge, then releases
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h0, r, e);
      chk(nm, exp, r);
      chk("slave error", {31'h0, ee}, {31'h0, e});
   endtask
   task automatic wait_st(input logic [2:0] s, input int lim);
      int k;
      k = 0;
      while (state !== s && k < lim) begin
         @(posedge pclk);
         k++;
      end
      chk("power state", {29'h0, s}, {29'h0, state});
   endtask
   task automatic press(input int ms);
      btn <= 1'b0;
      repeat (ms * CMS) @(posedge pclk);
      btn <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask
   task automatic pulse(input logic [7:0] a);
      act <= a;
      @(posedge pclk);
      act <= 8'h0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic ring_edge();
      ring <= 1'b1;
      repeat (6) @(posedge pclk);
      ring <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      complete_run();
   end
   initial begin
      static logic [7:0] ix [9] = '{IDX_STATE, IDX_CONTROL, IDX_ACT_MASK, IDX_IRQ_STATUS, IDX_IRQ_MASK,
                             IDX_IDLE_TIMER, IDX_DISP_TIMER, IDX_SUSP_TIMER, IDX_RESUME_DLY};
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, bcrit, bcaut, ring} = '0;
      {btn, rst_n} = 2'b11;
      paddr = '0;
      pwdata = '0;
      act = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 9; i++) rdc("reset value", ix[i], (ix[i] == IDX_ACT_MASK) ? 32'hff : 32'h0, 1'b0);
      rdc("unmapped", 8'hd0, 32'h0, 1'b1);
      wr(IDX_STATE, 8'h03);
      rdc("state read only", IDX_STATE, 32'h0, 1'b0);
      chk("power pins", 32'h1f, {27'h0, mem, bias, bias_oe, lcd, lcd_oe});
      wr(IDX_RESUME_DLY, 8'hff);
      rdc("resume delay readback", IDX_RESUME_DLY, 32'hff, 1'b0);
      $display("done: registers");
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_IDLE_TIMER, 8'h02);
      wait_st(PSM_IDLE_SLOW, 100);
      chk("idle irq", 32'h1, {31'h0, irq});
      wr(IDX_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      repeat (100) @(posedge pclk);
      chk("zero timer", {29'h0, PSM_IDLE_SLOW}, {29'h0, state});
      wr(IDX_ACT_MASK, 8'hfe);
      pulse(8'h01);
      chk("masked activity", {29'h0, PSM_IDLE_SLOW}, {29'h0, state});
      wr(IDX_CONTROL, 8'h20);
      @(posedge pclk);
      chk("idle halt", 32'h1, {31'h0, halt});
      wr(IDX_IDLE_TIMER, 8'h00);
      pulse(8'h02);
      wait_st(PSM_FULL_RUN, 10);
      rdc("activity status", IDX_IRQ_STATUS, 32'h20, 1'b0);
      $display("done: idle and activity");
      wr(IDX_CONTROL, 8'h12);
      ce <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("clock enable freeze", 32'h0, {31'h0, slow});
      ce <= 1'b1;
      repeat (30) @(posedge pclk);
      chk("governor slow", 32'h1, {31'h0, slow});
      pulse(8'h02);
      chk("governor fast", 32'h0, {31'h0, slow});
      wr(IDX_CONTROL, 8'h02);
      wr(IDX_IRQ_STATUS, 8'hff);
      press(40);
      rdc("short press", IDX_IRQ_STATUS, 32'h0, 1'b0);
      press(64);
      bcrit <= 1'b1;
      bcaut <= 1'b1;
      repeat (6) @(posedge pclk);
      rdc("press and battery", IDX_IRQ_STATUS, 32'h0e, 1'b0);
      $display("done: button awake");
      wr(IDX_RESUME_DLY, 8'h02);
      wr(IDX_IRQ_STATUS, 8'hff);
      wr(IDX_COMMAND, 8'h01);
      wait_st(PSM_SUSPENDED, 10);
      repeat (6) @(posedge pclk);
      chk("system power off", 32'h0, {31'h0, sys_pwr});
      chk("suspend pins", 32'h15, {27'h0, mem, bias, bias_oe, lcd, lcd_oe});
      press(64);
      n = 0;
      while (pgood !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      while (state !== PSM_FULL_RUN && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk("resume delay", 32'h1, 32'(n >= 2 * CMS && n < 2 * CMS + 10));
      rdc("resume status", IDX_IRQ_STATUS, 32'h10, 1'b0);
      $display("done: suspend and button");
      wr(IDX_IDLE_TIMER, 8'h01);
      wr(IDX_DISP_TIMER, 8'h01);
      wr(IDX_SUSP_TIMER, 8'h01);
      wait_st(PSM_IDLE_SLOW, 60);
      wait_st(PSM_DISPLAY_OFF, 100);
      wait_st(PSM_SUSPENDED, 100);
      for (int i = 5; i < 8; i++) wr(ix[i], 8'h00);
      ring_edge();
      chk("one ring edge", {29'h0, PSM_SUSPENDED}, {29'h0, state});
      ring_edge();
      wait_st(PSM_FULL_RUN, 200);
      wr(IDX_CONTROL, 8'h42);
      wr(IDX_COMMAND, 8'h03);
      wait_st(PSM_POWERED_OFF, 10);
      press(64);
      chk("button in off", {29'h0, PSM_POWERED_OFF}, {29'h0, state});
      chk("off pins", 32'h00, {27'h0, mem, bias, bias_oe, lcd, lcd_oe});
      ring_edge();
      ring_edge();
      wait_st(PSM_FULL_RUN, 200);
      $display("done: timers, ring and off");
      complete_run();
   end
endmodule // test_power_state_manager
`default_nettype wire
